/* bench/dmt_dev_model.sv */
/*
  Device model: watches packets, power pins and the serial window of the controller.
  Assumes every controller output changes on clk_sys, one packet slot per cycle.
*/
`timescale 1ns/10ps
module dmt_dev_model (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // Controller outputs
    input  wire logic              pktValid,
    input  wire dmt_pkg::dmt_pkt_s pkt,
    input  wire logic              powerdownState,
    input  wire logic              masterClockPairRun,
    input  wire logic              serGrant,
    // Breaches seen
    output int                     errCnt
);
    int                            gPkt, gCal, gEnd, gWake, gSer, gRef, gPdn, gClk, refRun;
    logic                          lastPre, pdWas, isCal, isEnd, isRef, bad;
    logic [dmt_pkg::REF_ADDR_W-1:0] nextRef;   // Next row expected from the refresh walk

    // Flag any breach in this cycle
    always_comb
    begin
        isCal = pkt.kind inside {dmt_pkg::KIND_CURRENT_CAL, dmt_pkg::KIND_TERMINATION_CAL};
        isEnd = pkt.kind == dmt_pkg::KIND_CAL_END;
        isRef = pkt.kind == dmt_pkg::KIND_INTERLEAVED_REFRESH;
        bad = pktValid && ((isCal && gPkt < (lastPre ? 4 : 16)) || (isEnd && gCal < 12)
            || (!isEnd && gEnd < 24));
        // quiet periods; the serial bound allows one tick of phase
        bad |= pktValid && (powerdownState || gWake < 4096 || serGrant || gSer < 45);
        bad |= pktValid && isRef && (pkt.refAddr != nextRef || (refRun == 128 && gRef < 40));
        bad |= powerdownState && !pdWas && gPkt < 16;
        bad |= powerdownState && !masterClockPairRun && gPdn < 16;
        bad |= !powerdownState && pdWas && gClk < 16;
    end

    // Advance the counters and tally breaches
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            errCnt <= 0;
            {gPkt, gCal, gEnd, gWake, gSer, gRef} <= {6{32'h0000_270F}};
            {gPdn, gClk, refRun} <= '0;
            {lastPre, pdWas} <= 2'h0;
            nextRef <= '0;
        end
        else
        begin
            errCnt <= errCnt + int'(bad);
            gPkt <= pktValid ? 1 : gPkt + 1;
            gCal <= (pktValid && isCal) ? 1 : gCal + 1;
            gEnd <= (pktValid && isEnd) ? 1 : gEnd + 1;
            gRef <= (pktValid && isRef) ? 1 : gRef + 1;
            gWake <= (!powerdownState && pdWas) ? 1 : gWake + 1;
            gSer <= serGrant ? 0 : gSer + 1;
            gPdn <= powerdownState ? gPdn + 1 : 0;
            gClk <= masterClockPairRun ? gClk + 1 : 0;
            pdWas <= powerdownState;
            // Refresh packets close rows too, so they earn the short lead
            if (pktValid)
                lastPre <= pkt.kind == dmt_pkg::KIND_USER_PRECHARGE || isRef;
            if (pktValid && isRef)
            begin
                nextRef <= pkt.refAddr + 1'b1;
                refRun  <= (gRef == 1) ? refRun + 1 : 1;
            end
        end
    end
endmodule

/* bench/dmt_maint_ctrl_tb_top.sv */
/*
  Self-checking bench for the maintenance timing controller.
  Assumes the package and the device model are compiled first.
*/
`timescale 1ns/10ps
`define CHK(a, b) \
    begin \
        comparisons++; \
        if ((a) !== (b)) \
        begin \
            errors++; \
            $display("[ERR] %0t %h %h", $time, (a), (b)); \
        end \
    end
module dmt_maint_ctrl_tb_top;
    localparam logic [31:0]    INIT_T = 32'h0000_0014;  // Short init delay
    localparam logic [31:0]    CAL_T  = 32'h0000_0190;  // Short calibration period
    logic                      clk_sys, rst_n, cmdValid, cmdPrecharge, cmdAck, pdReq;
    logic                      serReq, serDone, serGrant, pktValid, powerdownState;
    logic                      masterClockPairRun;
    logic [dmt_pkg::REQ_W-1:0] cmdPayload;
    dmt_pkg::dmt_pkt_s         pkt;
    int                        errors, comparisons, devErr, n;

    dmt_maint_ctrl #(.INIT_CYC(INIT_T), .CAL_CYC(CAL_T)) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .cmdValid(cmdValid), .cmdPrecharge(cmdPrecharge),
        .cmdPayload(cmdPayload), .cmdAck(cmdAck), .pdReq(pdReq), .serReq(serReq),
        .serDone(serDone), .serGrant(serGrant), .pktValid(pktValid), .pkt(pkt),
        .powerdownState(powerdownState), .masterClockPairRun(masterClockPairRun));
    dmt_dev_model i_dev (
        .clk_sys(clk_sys), .rst_n(rst_n), .pktValid(pktValid), .pkt(pkt),
        .powerdownState(powerdownState), .masterClockPairRun(masterClockPairRun),
        .serGrant(serGrant), .errCnt(devErr));

    // Free-running 250 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic end_of_test();
        if (errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wt(input int c);
        repeat (c) @(negedge clk_sys);
    endtask

    // Wait for a packet of one kind; c ends at lim if none came
    task automatic waitPkt(input dmt_pkg::dmt_kind_e k, input int lim, output int c);
        for (c = 0; c < lim && !(pktValid === 1'b1 && pkt.kind === k); c++)
            @(negedge clk_sys);
    endtask

    // Init hold-off, then a held request is served with its payload
    task automatic test_init();
        `CHK({cmdAck, serGrant, pktValid, powerdownState, masterClockPairRun}, 5'h01)
        rst_n = 1'b1;
        cmdPayload = 24'hA5A5A5;
        cmdValid = 1'b1;
        waitPkt(dmt_pkg::KIND_USER, 300, n);
        `CHK(n > INIT_T, 1'b1)
        `CHK({cmdAck, pkt.payload}, 25'h1A5A5A5)
        // Back-to-back: precharge request followed by a plain one
        cmdPrecharge = 1'b1;
        cmdPayload = 24'h123456;
        waitPkt(dmt_pkg::KIND_USER_PRECHARGE, 500, n);
        `CHK(pkt.payload, 24'h123456)
        cmdPrecharge = 1'b0;
        cmdPayload = 24'h00ABCD;
        waitPkt(dmt_pkg::KIND_USER, 500, n);
        `CHK(pkt.payload, 24'h00ABCD)
        cmdValid = 1'b0;
    endtask

    // Idle run: refresh rate, then a long serial window builds a burst
    task automatic test_refresh();
        n = 0;
        repeat (3904)
        begin
            @(negedge clk_sys);
            n += int'(pktValid === 1'b1 && pkt.kind === dmt_pkg::KIND_INTERLEAVED_REFRESH);
        end
        `CHK(n >= 31, 1'b1)
        serReq = 1'b1;
        for (n = 0; n < 200 && serGrant !== 1'b1; n++)
            @(negedge clk_sys);
        `CHK(serGrant, 1'b1)
        wt(16200);
        serDone = 1'b1;
        serReq = 1'b0;
        wt(1);
        serDone = 1'b0;
        wt(2);
        `CHK(serGrant, 1'b0)
        n = 0;
        repeat (1000)
        begin
            @(negedge clk_sys);
            n += int'(pktValid === 1'b1 && pkt.kind === dmt_pkg::KIND_INTERLEAVED_REFRESH);
        end
        `CHK(n >= 129, 1'b1)
        `CHK(devErr, 0)
    endtask

    // Calibration under a precharge stream, user traffic right after
    task automatic test_cal();
        cmdPrecharge = 1'b1;
        cmdValid = 1'b1;
        waitPkt(dmt_pkg::KIND_CURRENT_CAL, CAL_T + 600, n);
        `CHK(n < CAL_T + 600, 1'b1)
        waitPkt(dmt_pkg::KIND_CAL_END, 100, n);
        waitPkt(dmt_pkg::KIND_TERMINATION_CAL, 200, n);
        `CHK(n < 200, 1'b1)
        waitPkt(dmt_pkg::KIND_CAL_END, 100, n);
        waitPkt(dmt_pkg::KIND_USER_PRECHARGE, 100, n);
        `CHK(n < 100, 1'b1)
        waitPkt(dmt_pkg::KIND_CURRENT_CAL, CAL_T + 100, n);
        `CHK(n < CAL_T + 100, 1'b1)
        cmdValid = 1'b0;
        cmdPrecharge = 1'b0;
        `CHK(devErr, 0)
    endtask

    // Power-down entered with a request pending, then woken
    task automatic test_pdn();
        cmdValid = 1'b1;
        pdReq = 1'b1;
        for (n = 0; n < 300 && masterClockPairRun !== 1'b0; n++)
            @(negedge clk_sys);
        `CHK({powerdownState, masterClockPairRun}, 2'h2)
        wt(30);
        pdReq = 1'b0;
        for (n = 0; n < 300 && powerdownState !== 1'b0; n++)
            @(negedge clk_sys);
        `CHK({powerdownState, masterClockPairRun}, 2'h1)
        waitPkt(dmt_pkg::KIND_USER, 6000, n);
        `CHK(n >= 4096 && n < 6000, 1'b1)
        cmdValid = 1'b0;
        `CHK(devErr, 0)
    endtask

    // Watchdog well beyond the expected run length
    initial
    begin
        #240000;
        errors++;
        end_of_test();
    end

    // Main sequence, reset held for 16 cycles
    initial
    begin
        {rst_n, cmdValid, cmdPrecharge, pdReq, serReq, serDone} = 6'h00;
        cmdPayload = '0;
        errors = 0;
        comparisons = 0;
        wt(16);
        test_init();
        test_refresh();
        test_cal();
        test_pdn();
        end_of_test();
    end
endmodule

/* src/dmt_maint_ctrl.sv */
/*
  Host-side maintenance scheduler: refresh, calibration, power-down and serial handover.
  Assumes request strobes come from logic on clk_sys and that rst_n follows stable supply.
*/
`timescale 1ns/10ps
module dmt_maint_ctrl #(
    parameter logic [31:0] INIT_CYC = dmt_pkg::INIT_CYC,
    parameter logic [31:0] CAL_CYC  = dmt_pkg::CAL_CYC
) (
    // Clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           rst_n,
    // User request port
    input  wire logic                           cmdValid,
    input  wire logic                           cmdPrecharge,
    input  wire logic [dmt_pkg::REQ_W-1:0]      cmdPayload,
    output logic                                cmdAck,
    // Power and serial control
    input  wire logic                           pdReq,
    input  wire logic                           serReq,
    input  wire logic                           serDone,
    output logic                                serGrant,
    // Device side
    output logic                                pktValid,
    output dmt_pkg::dmt_pkt_s                   pkt,
    output logic                                powerdownState,
    output logic                                masterClockPairRun
);
    dmt_pkg::dmt_state_s cur_reg;   // Registered state
    dmt_pkg::dmt_state_s cur_next;  // Next state

    // Place one packet and restart the spacing counters
    function automatic dmt_pkg::dmt_state_s issuePkt(input dmt_pkg::dmt_state_s s,
                                                     input dmt_pkg::dmt_kind_e k);
        dmt_pkg::dmt_state_s r;
        r              = s;
        r.pktValid     = 1'b1;
        r.pkt.kind     = k;
        r.pkt.refAddr  = s.refAddr;
        r.sinceCmd     = 6'h01;
        r.serCnt       = 4'h0;
        r.lastPre      = (k == dmt_pkg::KIND_USER_PRECHARGE);
        return r;
    endfunction

    // Next-state logic
    always_comb
    begin
        cur_next          = cur_reg;
        cur_next.pktValid = 1'b0;
        cur_next.cmdAck   = 1'b0;
        // Saturating age since the last packet
        if (cur_reg.sinceCmd != 6'h3F)
        begin
            cur_next.sinceCmd = cur_reg.sinceCmd + 6'h01;
        end
        // Serial clock rate enable
        if (cur_reg.divCnt == dmt_pkg::SCK_DIV - 3'h1)
        begin
            cur_next.divCnt = 3'h0;
            if (cur_reg.serCnt != 4'hF)
            begin
                cur_next.serCnt = cur_reg.serCnt + 4'h1;
            end
        end
        else
        begin
            cur_next.divCnt = cur_reg.divCnt + 3'h1;
        end
        if (cur_reg.serCnt >= dmt_pkg::SER_GAP)
        begin
            cur_next.serHold = 1'b0;
        end
        if (cur_reg.refTick == dmt_pkg::REF_CYC - 8'h01)
        begin
            cur_next.refTick = 8'h00;
            if (cur_reg.refDebt != 8'hFF)
            begin
                cur_next.refDebt = cur_reg.refDebt + 8'h01;
            end
        end
        else
        begin
            cur_next.refTick = cur_reg.refTick + 8'h01;
        end
        // rest countdown after a full burst
        if (cur_reg.restCnt != 6'h00)
        begin
            cur_next.restCnt = cur_reg.restCnt - 6'h01;
        end
        cur_next.lastWasRef = 1'b0;
        if (cur_reg.calTimer >= CAL_CYC - 32'h1)
        begin
            cur_next.calDue = 1'b1;
        end
        else
        begin
            cur_next.calTimer = cur_reg.calTimer + 32'h1;
        end
        unique case (cur_reg.st)
            dmt_pkg::ST_INIT:
            begin
                // hold everything until init delay ends
                cur_next.waitCnt = cur_reg.waitCnt + 32'h1;
                if (cur_reg.waitCnt >= INIT_CYC)
                begin
                    cur_next.st = dmt_pkg::ST_RUN;
                end
            end
            dmt_pkg::ST_RUN:
            begin
                // serial hold blocks every packet source
                if (cur_reg.serHold)
                begin
                    cur_next.st = dmt_pkg::ST_RUN;
                end
                else if (cur_reg.calDue)
                begin
                    cur_next.calTerm = 1'b0;
                    cur_next.st      = dmt_pkg::ST_CALGAP;
                end
                else if (pdReq)
                begin
                    if (cur_reg.sinceCmd >= dmt_pkg::CMD_PDN_GAP)
                    begin
                        cur_next.powerdownState = 1'b1;
                        cur_next.waitCnt        = 32'h0;
                        cur_next.st             = dmt_pkg::ST_PDN;
                    end
                end
                // serial window only after gap since packet
                else if (serReq)
                begin
                    if (cur_reg.serCnt >= dmt_pkg::SER_GAP)
                    begin
                        cur_next.serGrant = 1'b1;
                        cur_next.st       = dmt_pkg::ST_SER;
                    end
                end
                // refresh while owed and burst not exhausted
                else if (cur_reg.refDebt != 8'h00 && cur_reg.restCnt == 6'h00)
                begin
                    cur_next = issuePkt(cur_next, dmt_pkg::KIND_INTERLEAVED_REFRESH);
                    cur_next.refDebt    = cur_next.refDebt - 8'h01;
                    // bank and row walk covers whole array
                    cur_next.refAddr    = cur_reg.refAddr + 15'h0001;
                    cur_next.lastWasRef = 1'b1;
                    cur_next.burstCnt   = cur_reg.lastWasRef ?
                                          cur_reg.burstCnt + 8'h01 : 8'h01;
                    if (cur_next.burstCnt == dmt_pkg::BURST_MAX)
                    begin
                        cur_next.restCnt  = dmt_pkg::BURST_GAP;
                        cur_next.burstCnt = 8'h00;
                    end
                end
                else if (cmdValid)
                begin
                    cur_next = issuePkt(cur_next, cmdPrecharge ?
                                        dmt_pkg::KIND_USER_PRECHARGE : dmt_pkg::KIND_USER);
                    cur_next.pkt.payload = cmdPayload;
                    cur_next.cmdAck      = 1'b1;
                end
            end
            dmt_pkg::ST_CALGAP:
            begin
                // lead depends on previous packet type
                if (cur_reg.sinceCmd >= (cur_reg.lastPre ? dmt_pkg::CAL_LEAD_PRE
                                                         : dmt_pkg::CAL_LEAD_ANY))
                begin
                    cur_next = issuePkt(cur_next, cur_reg.calTerm ?
                               dmt_pkg::KIND_TERMINATION_CAL : dmt_pkg::KIND_CURRENT_CAL);
                    cur_next.st = dmt_pkg::ST_CALHOLD;
                end
            end
            dmt_pkg::ST_CALHOLD:
            begin
                if (cur_reg.sinceCmd >= dmt_pkg::CAL_END_GAP)
                begin
                    cur_next    = issuePkt(cur_next, dmt_pkg::KIND_CAL_END);
                    cur_next.st = dmt_pkg::ST_CALEND;
                end
            end
            dmt_pkg::ST_CALEND:
            begin
                // no command until gap after end packet
                if (cur_reg.sinceCmd >= dmt_pkg::CALIBRATION_END_CMD_CMD_GAP)
                begin
                    if (!cur_reg.calTerm)
                    begin
                        cur_next.calTerm = 1'b1;
                        cur_next.st      = dmt_pkg::ST_CALGAP;
                    end
                    else
                    begin
                        cur_next.calDue   = 1'b0;
                        cur_next.calTimer = 32'h0;
                        cur_next.st       = dmt_pkg::ST_RUN;
                    end
                end
            end
            dmt_pkg::ST_SER:
            begin
                // Serial owner returns the bus; hold packets for the gap
                if (serDone)
                begin
                    cur_next.serGrant = 1'b0;
                    cur_next.serCnt   = 4'h0;
                    cur_next.serHold  = 1'b1;
                    cur_next.st       = dmt_pkg::ST_RUN;
                end
            end
            dmt_pkg::ST_PDN:
            begin
                if (cur_reg.waitCnt < dmt_pkg::PDN_CLK_HOLD)
                begin
                    cur_next.waitCnt = cur_reg.waitCnt + 32'h1;
                end
                else if (cur_reg.masterClockPairRun)
                begin
                    cur_next.masterClockPairRun = 1'b0;
                end
                else if (!pdReq)
                begin
                    cur_next.masterClockPairRun = 1'b1;
                    cur_next.waitCnt            = 32'h0;
                    cur_next.st                 = dmt_pkg::ST_WAKE;
                end
            end
            dmt_pkg::ST_WAKE:
            begin
                // Device self-refreshed while asleep, so owed refreshes lapse
                cur_next.refDebt = 8'h00;
                cur_next.waitCnt = cur_reg.waitCnt + 32'h1;
                if (cur_reg.powerdownState && cur_reg.waitCnt >= dmt_pkg::CLK_PDN_LEAD)
                begin
                    cur_next.powerdownState = 1'b0;
                    cur_next.waitCnt        = 32'h0;
                end
                else if (!cur_reg.powerdownState &&
                         cur_reg.waitCnt >= dmt_pkg::PDN_CMD_LOCK - 32'h1)
                begin
                    cur_next.st = dmt_pkg::ST_RUN;
                end
            end
            default:
            begin
                cur_next.st = dmt_pkg::ST_INIT;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cur_reg                    <= '0;
            cur_reg.masterClockPairRun <= 1'b1;
            cur_reg.sinceCmd           <= 6'h3F;
            cur_reg.serCnt             <= 4'hF;
        end
        else
        begin
            cur_reg <= cur_next;
        end
    end

    assign cmdAck             = cur_reg.cmdAck;
    assign serGrant           = cur_reg.serGrant;
    assign pktValid           = cur_reg.pktValid;
    assign pkt                = cur_reg.pkt;
    assign powerdownState     = cur_reg.powerdownState;
    assign masterClockPairRun = cur_reg.masterClockPairRun;

    // Observers for the checks: packet age, burst run, clock and wake ages
    logic [5:0]  gapObs;
    dmt_pkg::dmt_kind_e lastKind;
    logic [8:0]  runObs;
    logic [5:0]  clkAge;
    logic [12:0] wakeAge;
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            gapObs   <= 6'h3F;
            lastKind <= dmt_pkg::KIND_USER;
            runObs   <= 9'h000;
            clkAge   <= 6'h00;
            wakeAge  <= 13'h1FFF;
        end
        else
        begin
            gapObs   <= pktValid ? 6'h01 : (gapObs == 6'h3F ? gapObs : gapObs + 6'h01);
            lastKind <= pktValid ? pkt.kind : lastKind;
            runObs   <= (pktValid && pkt.kind == dmt_pkg::KIND_INTERLEAVED_REFRESH) ?
                        runObs + 9'h001 : (gapObs == 6'h01 ? runObs : 9'h000);
            clkAge   <= !masterClockPairRun ? 6'h00 :
                        (clkAge == 6'h3F ? clkAge : clkAge + 6'h01);
            wakeAge  <= $fell(powerdownState) ? 13'h0001 :
                        (wakeAge == 13'h1FFF ? wakeAge : wakeAge + 13'h0001);
        end
    end

    a_cal_lead_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pktValid && (pkt.kind == dmt_pkg::KIND_CURRENT_CAL ||
        pkt.kind == dmt_pkg::KIND_TERMINATION_CAL) |->
        gapObs >= (lastKind == dmt_pkg::KIND_USER_PRECHARGE ? 6'h04 : 6'h10))
        else $error("calibration packet too close to previous packet");
    a_cal_end_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pktValid && pkt.kind == dmt_pkg::KIND_CAL_END |-> gapObs >= 6'h0C)
        else $error("calibration end too early");
    a_after_cal_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pktValid && lastKind == dmt_pkg::KIND_CAL_END |-> gapObs >= 6'h18)
        else $error("command too soon after calibration end");
    a_pdn_entry_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(powerdownState) |-> gapObs >= 6'h10)
        else $error("power-down entered too soon");
    a_clk_after_pdn: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(powerdownState) |-> masterClockPairRun [*8] ##1 masterClockPairRun [*8])
        else $error("clock stopped too soon after power-down entry");
    a_clk_before_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(powerdownState) |-> $past(clkAge) >= 6'h10)
        else $error("clock not stable before power-down exit");
    a_lock_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pktValid |-> wakeAge >= 13'h1000)
        else $error("command before clock lock");
    a_burst_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        runObs <= 9'h080)
        else $error("refresh burst too long");
    a_ser_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        serGrant |-> !pktValid && !$past(pktValid))
        else $error("packet during serial window");

    c_cal_end: cover property (@(posedge clk_sys) disable iff (!rst_n)
        pktValid && pkt.kind == dmt_pkg::KIND_CAL_END);
    c_pdn_exit: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(powerdownState));
    c_serial: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(serGrant));
    c_user_cmd: cover property (@(posedge clk_sys) disable iff (!rst_n) cmdAck);
endmodule

/* src/dmt_pkg.sv */
/*
  Constants, enumerations and carrier structs for the maintenance timing controller.
  Assumes one packet slot per clk_sys cycle, which is never shorter than a master clock cycle.
*/
// Notes on behaviour
// - Every row refreshed within 16 ms window
// - Refresh commands average no wider than 488 ns
// - Refresh pass walks 8 banks, 4096 rows
// - At most 128 back-to-back refresh commands
// - Forty cycles rest after a full burst
// - Wait 1.500 ms before first transaction
// - Both calibrations repeat within 100 ms
// - Calibration leads: 4 after precharge, else 16
// - Calibration end at least 12 cycles later
// - Twenty-four cycles after calibration end
// - Sixteen idle cycles before power-down entry
// - Clock pair runs 16 cycles after entry
// - Clock pair runs 16 cycles before exit
// - Wait 4096 cycles after exit for lock
// - Ten serial clocks between serial and packets
package dmt_pkg;
    localparam int          CLK_PERIOD_NS = 4;        // clk_sys period
    localparam int          REF_WINDOW_MS = 16;       // Whole-array refresh window
    localparam int          REF_AVG_NS    = 488;      // Longest average refresh spacing
    localparam logic [7:0]  REF_CYC       = 8'(REF_AVG_NS / CLK_PERIOD_NS);
    localparam int          BANK_W        = 3;        // 8 banks
    localparam int          ROW_W         = 12;       // 4096 rows per bank
    localparam int          REF_ADDR_W    = BANK_W + ROW_W;
    localparam logic [7:0]  BURST_MAX     = 8'h80;    // 128 refreshes
    localparam logic [5:0]  BURST_GAP     = 6'h28;    // 40 cycles
    localparam int          INIT_US       = 1500;     // 1.500 ms
    localparam logic [31:0] INIT_CYC      = 32'((INIT_US * 1000 + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS);
    localparam int          CAL_MS        = 100;      // Longest calibration interval
    localparam logic [31:0] CAL_CYC       = 32'(CAL_MS * 1000000 / CLK_PERIOD_NS);
    localparam logic [5:0]  CAL_LEAD_PRE  = 6'h04;    // After precharge-type packet
    localparam logic [5:0]  CAL_LEAD_ANY  = 6'h10;    // After any other packet
    localparam logic [5:0]  CAL_END_GAP   = 6'h0C;
    localparam logic [5:0]  CALIBRATION_END_CMD_CMD_GAP  = 6'h18;
    localparam logic [5:0]  CMD_PDN_GAP   = 6'h10;
    localparam logic [31:0] PDN_CLK_HOLD  = 32'h0000_0010;
    localparam logic [31:0] CLK_PDN_LEAD  = 32'h0000_0010;
    localparam logic [31:0] PDN_CMD_LOCK  = 32'h0000_1000;  // 4096 cycles
    localparam int          SCK_MIN_NS    = 20;
    localparam logic [2:0]  SCK_DIV       = 3'((SCK_MIN_NS + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS);
    localparam logic [3:0]  SER_GAP       = 4'hA;     // Serial clock cycles
    localparam int          REQ_W         = 24;       // User request payload

    // Controller phases, Gray along init, run and calibration
    typedef enum logic [2:0] {
        ST_INIT    = 3'b000,
        ST_RUN     = 3'b001,
        ST_CALGAP  = 3'b011,
        ST_CALHOLD = 3'b010,
        ST_CALEND  = 3'b110,
        ST_SER     = 3'b111,
        ST_PDN     = 3'b101,
        ST_WAKE    = 3'b100
    } dmt_state_e;

    // Packet kinds on the request bus
    typedef enum logic [2:0] {
        KIND_USER               = 3'h0,
        KIND_USER_PRECHARGE     = 3'h1,
        KIND_INTERLEAVED_REFRESH = 3'h2,
        KIND_CURRENT_CAL        = 3'h3,
        KIND_TERMINATION_CAL    = 3'h4,
        KIND_CAL_END            = 3'h5
    } dmt_kind_e;

    // One request bus packet
    typedef struct packed {
        dmt_kind_e               kind;
        logic [REF_ADDR_W-1:0]   refAddr;
        logic [REQ_W-1:0]        payload;
    } dmt_pkt_s;

    // Whole controller state
    typedef struct packed {
        dmt_state_e              st;
        dmt_pkt_s                pkt;
        logic                    pktValid;
        logic                    cmdAck;
        logic                    serGrant;
        logic                    powerdownState;
        logic                    masterClockPairRun;
        logic [5:0]              sinceCmd;
        logic                    lastPre;
        logic [7:0]              refTick;
        logic [7:0]              refDebt;
        logic [7:0]              burstCnt;
        logic                    lastWasRef;
        logic [5:0]              restCnt;
        logic [REF_ADDR_W-1:0]   refAddr;
        logic [31:0]             calTimer;
        logic                    calDue;
        logic                    calTerm;
        logic [31:0]             waitCnt;
        logic [2:0]              divCnt;
        logic [3:0]              serCnt;
        logic                    serHold;
    } dmt_state_s;
endpackage
